// file: hw/phy_link_port.sv
// Link-controller port: mode capture, request handling, register slave.
// Assumes all link pins are synchronous to aclk and an AXI4-Lite master.
`timescale 1ns/10ps
module phy_link_port #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_interface_mode_select,
  input wire logic link_clock_in,
  input wire logic lreq,
  input wire logic [7:0] phy_link_data_bus_in,
  input wire logic link_drives_bus,
  output logic [7:0] phy_link_data_bus_out,
  output logic phy_link_data_bus_oe,
  output logic [1:0] ctl_out,
  output logic ctl_oe,
  output logic link_interrupt_out,
  output logic iface_clk_fast,
  output logic mode_1394b,
  output logic arb_accel_enable,
  output logic multispeed_concat_enable,
  output logic bus_req_valid,
  output logic [2:0] bus_req_speed,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // Data lane mask by speed
  // ----------------------------------------------------------------
  function automatic logic [7:0] lane_mask(input logic [2:0] speed);
    if (speed == phy_link_pkg::SPD_S100) begin
      lane_mask = phy_link_pkg::LANE_S100;
    end else if (speed == phy_link_pkg::SPD_S200) begin
      lane_mask = phy_link_pkg::LANE_S200;
    end else begin
      lane_mask = phy_link_pkg::LANE_ALL;
    end
  endfunction : lane_mask

  logic dec_valid;
  phy_link_pkg::lreq_s dec_req;
  phy_link_pkg::lreq_s last_req_reg;
  phy_link_pkg::null_state_e null_state_reg;
  logic mode_reg;
  logic link_clk_seen_reg;
  logic [15:0] null_count_reg;
  logic [7:0] link_data_reg;
  logic [2:0] cur_speed_reg;
  logic is_bus_req;
  logic speed_ok;
  logic start_null;
  logic wr_fire;
  logic rd_fire;

  lreq_decoder u_dec (
    .aclk(aclk),
    .aresetn(aresetn),
    .lreq(lreq),
    .req_valid(dec_valid),
    .req(dec_req)
  );

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  // Sampled only while reset is low; later changes have no effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= link_interface_mode_select;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_1394b <= 1'b0;
      iface_clk_fast <= 1'b0;
      link_interrupt_out <= 1'b0;
    end else begin
      mode_1394b <= mode_reg;
      // Selects the PLL tap that feeds the link system clock
      iface_clk_fast <= mode_reg;
      // Unused in the legacy interface; no interrupt source here
      link_interrupt_out <= 1'b0;
    end
  end

  // Link clock pin is expected grounded in legacy mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_clk_seen_reg <= 1'b0;
    end else if (!mode_reg && link_clock_in) begin
      link_clk_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus request handling
  // ----------------------------------------------------------------
  assign is_bus_req = dec_valid && (dec_req.kind < phy_link_pkg::REQ_READ);
  assign speed_ok = (dec_req.speed == phy_link_pkg::SPD_S100) || (dec_req.speed == phy_link_pkg::SPD_S200)
    || (dec_req.speed == phy_link_pkg::SPD_S400);
  assign start_null = is_bus_req && !mode_reg && !speed_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_req_valid <= 1'b0;
      bus_req_speed <= 3'h0;
      last_req_reg <= '0;
    end else begin
      bus_req_valid <= is_bus_req && !start_null;
      if (is_bus_req && !start_null) begin
        bus_req_speed <= dec_req.speed;
      end
      if (dec_valid) begin
        last_req_reg <= dec_req;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_speed_reg <= phy_link_pkg::SPD_S100;
    end else if (is_bus_req && speed_ok) begin
      cur_speed_reg <= dec_req.speed;
    end
  end

  // ----------------------------------------------------------------
  // Null packet: data-prefix then data-end, no payload
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      null_state_reg <= phy_link_pkg::N_IDLE;
    end else begin
      case (null_state_reg)
        phy_link_pkg::N_IDLE: begin
          if (start_null) begin
            null_state_reg <= phy_link_pkg::N_PREFIX;
          end
        end
        phy_link_pkg::N_PREFIX: begin
          null_state_reg <= phy_link_pkg::N_END;
        end
        phy_link_pkg::N_END: begin
          null_state_reg <= phy_link_pkg::N_IDLE;
        end
        default: begin
          null_state_reg <= phy_link_pkg::N_IDLE;
        end
      endcase
    end
  end

  // Device drives ctl and data itself; no isolation barrier behind the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_out <= phy_link_pkg::CTL_IDLE;
      ctl_oe <= 1'b1;
      phy_link_data_bus_out <= 8'h00;
      phy_link_data_bus_oe <= 1'b1;
    end else begin
      ctl_oe <= !link_drives_bus;
      phy_link_data_bus_oe <= !link_drives_bus;
      if (null_state_reg == phy_link_pkg::N_PREFIX) begin
        ctl_out <= phy_link_pkg::CTL_RECEIVE;
        phy_link_data_bus_out <= phy_link_pkg::DATA_PREFIX_BYTE & lane_mask(cur_speed_reg);
      end else begin
        ctl_out <= phy_link_pkg::CTL_IDLE;
        phy_link_data_bus_out <= phy_link_pkg::DATA_END_BYTE & lane_mask(cur_speed_reg);
      end
    end
  end

  // Inbound lanes above the current speed are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_data_reg <= 8'h00;
      null_count_reg <= 16'h0000;
    end else begin
      if (link_drives_bus) begin
        link_data_reg <= phy_link_data_bus_in & lane_mask(cur_speed_reg);
      end
      if (start_null) begin
        null_count_reg <= null_count_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_fire = awvalid && wvalid && !awready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= phy_link_pkg::RESP_OKAY;
      arb_accel_enable <= phy_link_pkg::CONTROL_RESET[0];
      multispeed_concat_enable <= phy_link_pkg::CONTROL_RESET[1];
    end else begin
      awready <= wr_fire;
      wready <= wr_fire;
      // Response only after the address and data handshake edge
      if (awready) begin
        bvalid <= 1'b1;
        if (awaddr[7:0] == phy_link_pkg::CONTROL_OFFSET) begin
          bresp <= phy_link_pkg::RESP_OKAY;
          if (wstrb[0]) begin
            arb_accel_enable <= wdata[phy_link_pkg::CTRL_EAA_BIT];
            multispeed_concat_enable <= wdata[phy_link_pkg::CTRL_EMC_BIT];
          end
        end else begin
          bresp <= phy_link_pkg::RESP_SLVERR;
        end
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_fire = arvalid && !arready && !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= phy_link_pkg::RESP_OKAY;
    end else begin
      arready <= rd_fire;
      // Read data only after the address handshake edge
      if (arready) begin
        rvalid <= 1'b1;
        rresp <= phy_link_pkg::RESP_OKAY;
        case (araddr[7:0])
          phy_link_pkg::CONTROL_OFFSET: begin
            rdata <= {30'h00000000, multispeed_concat_enable, arb_accel_enable};
          end
          phy_link_pkg::STATUS_OFFSET: begin
            rdata <= {29'h00000000, link_clk_seen_reg, iface_clk_fast, mode_reg};
          end
          phy_link_pkg::LAST_REQ_OFFSET: begin
            rdata <= {5'h00, last_req_reg.kind, 5'h00, last_req_reg.speed, 4'h0, last_req_reg.addr,
                      last_req_reg.data};
          end
          phy_link_pkg::NULL_COUNT_OFFSET: begin
            rdata <= {16'h0000, null_count_reg};
          end
          phy_link_pkg::LINK_DATA_OFFSET: begin
            rdata <= {24'h000000, link_data_reg};
          end
          default: begin
            rdata <= 32'h00000000;
            rresp <= phy_link_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence null_walk;
    (null_state_reg == phy_link_pkg::N_PREFIX) ##1 (ctl_out == phy_link_pkg::CTL_RECEIVE)
      ##1 (ctl_out == phy_link_pkg::CTL_IDLE);
  endsequence

  chk_null_prefix_end: assert property (@(posedge aclk) disable iff (!aresetn)
    start_null |=> null_walk)
    else $error("null packet not prefix then end");

  chk_null_legacy_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_reg && is_bus_req) |=> (null_state_reg == phy_link_pkg::N_IDLE) && bus_req_valid)
    else $error("newer mode request not forwarded");

  chk_fast_speed_null: assert property (@(posedge aclk) disable iff (!aresetn)
    (!mode_reg && is_bus_req && !speed_ok) |=> !bus_req_valid ##1 (ctl_out == phy_link_pkg::CTL_RECEIVE))
    else $error("unsupported speed forwarded in legacy mode");

  chk_lane_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur_speed_reg == phy_link_pkg::SPD_S100) |=> ((phy_link_data_bus_out & ~phy_link_pkg::LANE_S100) == 8'h00)
      || ($past(cur_speed_reg) != phy_link_pkg::SPD_S100))
    else $error("unused data lanes driven high");

  chk_mode_static: assert property (@(posedge aclk) disable iff (!aresetn)
    $stable(mode_reg) && (iface_clk_fast == mode_1394b))
    else $error("mode changed outside reset");

  chk_int_unused: assert property (@(posedge aclk) disable iff (!aresetn)
    !link_interrupt_out)
    else $error("interrupt output driven in legacy interface");

  sequence wr_walk;
    (awready && wready && !bvalid) ##1 (bvalid && !awready);
  endsequence

  chk_bresp_after_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> wr_walk)
    else $error("write response not raised after handshake");

  chk_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> rvalid && $stable(rdata))
    else $error("read data dropped before accepted");

  chk_req_forward: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_bus_req && speed_ok) |=> bus_req_valid && (bus_req_speed == $past(dec_req.speed)))
    else $error("bus request not forwarded with its speed");

endmodule : phy_link_port

// file: hw/phy_link_pkg.sv
// Constants, types and register map for the link-controller port block.
// Assumes one 200 MHz clock and an AXI4-Lite master on the register side.
//
// Operation
// - Mode input high selects newer link interface
// - Mode input low selects legacy link interface
// - No bus-holder-free isolation method offered
// - Legacy mode: interface clock feeds link clock
// - Interface clock 49.152 or 98.304 MHz
// - Decode 7-bit and 8-bit bus requests
// - Back-to-back request after 7-bit request decoded
// - Legacy mode: speed other than S100, S200 or S400 sends null
// - Launch and sample on rising clock edge
// - Unused data lanes driven low, ignored inbound
package phy_link_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] LAST_REQ_OFFSET = 8'h08;
  localparam logic [7:0] NULL_COUNT_OFFSET = 8'h0C;
  localparam logic [7:0] LINK_DATA_OFFSET = 8'h10;
  localparam int CTRL_EAA_BIT = 0;
  localparam int CTRL_EMC_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_MHZ = 200.0;
  localparam real RESET_HOLD_MS = 2.0;
  localparam int RESET_HOLD_CYCLES = int'(RESET_HOLD_MS * CLK_MHZ * 1000.0);
  localparam real IFACE_CLK_SLOW_MHZ = 49.152;
  localparam real IFACE_CLK_FAST_MHZ = 98.304;
  localparam int IFACE_CLK_PPM = 100;

  // ----------------------------------------------------------------
  // Link request coding
  // ----------------------------------------------------------------
  localparam logic [2:0] REQ_READ = 3'h4;
  localparam logic [2:0] REQ_WRITE = 3'h5;
  localparam logic [2:0] REQ_ACCEL = 3'h6;
  localparam logic [3:0] PLEN_BUS = 4'h3;
  localparam logic [3:0] PLEN_READ = 4'h4;
  localparam logic [3:0] PLEN_WRITE = 4'hC;
  localparam logic [3:0] PLEN_OTHER = 4'h1;
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h2;
  localparam logic [2:0] SPD_S400 = 3'h4;
  localparam logic [7:0] LANE_S100 = 8'h03;
  localparam logic [7:0] LANE_S200 = 8'h0F;
  localparam logic [7:0] LANE_ALL = 8'hFF;

  // ----------------------------------------------------------------
  // Null packet line coding
  // ----------------------------------------------------------------
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [7:0] DATA_PREFIX_BYTE = 8'hFF;
  localparam logic [7:0] DATA_END_BYTE = 8'h00;

  typedef struct packed {
    logic [2:0] kind;
    logic [2:0] speed;
    logic [3:0] addr;
    logic [7:0] data;
  } lreq_s;

  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_COLLECT = 3'b010,
    D_STOP = 3'b100
  } dec_state_e;

  typedef enum logic [2:0] {
    N_IDLE = 3'b001,
    N_PREFIX = 3'b010,
    N_END = 3'b100
  } null_state_e;

endpackage : phy_link_pkg

// file: hw/lreq_decoder.sv
// Serial link request decoder.
// Assumes the request line is synchronous to aclk, one bit per cycle.
`timescale 1ns/10ps
module lreq_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lreq,
  output logic req_valid,
  output phy_link_pkg::lreq_s req
);

  // ----------------------------------------------------------------
  // Payload length by request kind
  // ----------------------------------------------------------------
  function automatic logic [3:0] payload_len(input logic [2:0] kind);
    if (kind < phy_link_pkg::REQ_READ) begin
      payload_len = phy_link_pkg::PLEN_BUS;
    end else if (kind == phy_link_pkg::REQ_READ) begin
      payload_len = phy_link_pkg::PLEN_READ;
    end else if (kind == phy_link_pkg::REQ_WRITE) begin
      payload_len = phy_link_pkg::PLEN_WRITE;
    end else begin
      payload_len = phy_link_pkg::PLEN_OTHER;
    end
  endfunction : payload_len

  phy_link_pkg::dec_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [2:0] kind_reg;
  logic [11:0] pl_reg;
  logic [11:0] pl_full;
  logic last_bit;

  assign pl_full = {pl_reg[10:0], lreq};
  assign last_bit = (state_reg == phy_link_pkg::D_COLLECT) && (cnt_reg >= 4'h3)
    && ((cnt_reg - 4'h3 + 4'h1) == payload_len(kind_reg));

  // ----------------------------------------------------------------
  // Bit collection
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= phy_link_pkg::D_IDLE;
      cnt_reg <= 4'h0;
      kind_reg <= 3'h0;
      pl_reg <= 12'h000;
    end else begin
      case (state_reg)
        phy_link_pkg::D_IDLE: begin
          if (lreq) begin
            state_reg <= phy_link_pkg::D_COLLECT;
            cnt_reg <= 4'h0;
            pl_reg <= 12'h000;
          end
        end
        phy_link_pkg::D_COLLECT: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg < 4'h3) begin
            kind_reg <= {kind_reg[1:0], lreq};
          end else begin
            pl_reg <= pl_full;
          end
          if (last_bit) begin
            // Third speed bit low: either a 7-bit stop or an 8-bit low bit
            if (kind_reg < phy_link_pkg::REQ_READ && !lreq) begin
              state_reg <= phy_link_pkg::D_IDLE;
            end else begin
              state_reg <= phy_link_pkg::D_STOP;
            end
          end
        end
        phy_link_pkg::D_STOP: begin
          state_reg <= phy_link_pkg::D_IDLE;
        end
        default: begin
          state_reg <= phy_link_pkg::D_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Decoded request out
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_valid <= 1'b0;
      req <= '0;
    end else begin
      req_valid <= last_bit;
      if (last_bit) begin
        req.kind <= kind_reg;
        // Two-bit legacy code lands in the upper bits of the 3-bit code
        req.speed <= (kind_reg < phy_link_pkg::REQ_READ) ? pl_full[2:0] : 3'h0;
        req.addr <= (kind_reg == phy_link_pkg::REQ_WRITE) ? pl_full[11:8] : pl_full[3:0];
        req.data <= (kind_reg == phy_link_pkg::REQ_WRITE) ? pl_full[7:0] : {7'h00, pl_full[0]};
      end
    end
  end

  chk_emit_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    req_valid |=> !req_valid)
    else $error("request valid held longer than one cycle");

endmodule : lreq_decoder

// file: dv/link_ctrl_model.sv
// Link-layer controller model on the far side of the port.
// Assumes it is clocked by the port's aclk.
`timescale 1ns/10ps
module link_ctrl_model (
  input wire logic aclk,
  output logic lreq,
  output logic link_drives_bus,
  output logic [7:0] phy_link_data_bus_in,
  output logic link_clock_in
);
  logic bits_q[$];

  initial begin
    lreq = 1'b0;
    link_drives_bus = 1'b0;
    phy_link_data_bus_in = 8'h00;
    link_clock_in = 1'b0;
  end

  // Request line, one bit per rising edge
  always @(posedge aclk) begin
    lreq <= (bits_q.size() > 0) ? bits_q.pop_front() : 1'b0;
  end

  task push_bits(input logic [19:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) bits_q.push_back(v[i]);
  endtask : push_bits

  function int pending();
    return bits_q.size();
  endfunction : pending

  // Released bus shows the inverse of the last value
  task drive_bus(input logic [7:0] v, input int n);
    @(posedge aclk);
    link_drives_bus <= 1'b1;
    phy_link_data_bus_in <= v;
    repeat (n) @(posedge aclk);
    link_drives_bus <= 1'b0;
    phy_link_data_bus_in <= ~v;
  endtask : drive_bus
endmodule : link_ctrl_model

// file: dv/tb_phy_link_port.sv
// Self-checking bench for the link-controller port.
// Assumes the link model file and the design package are compiled first.
`timescale 1ns/10ps
module tb_phy_link_port;
  logic aclk, aresetn, link_interface_mode_select, link_clock_in, lreq, link_drives_bus;
  logic [7:0] phy_link_data_bus_in, phy_link_data_bus_out, awaddr, araddr;
  logic phy_link_data_bus_oe, ctl_oe, link_interrupt_out, iface_clk_fast, mode_1394b;
  logic arb_accel_enable, multispeed_concat_enable, bus_req_valid;
  logic [1:0] ctl_out, bresp, rresp, r;
  logic [2:0] bus_req_speed;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd, rng, v;
  logic [3:0] wstrb;
  logic mode_exp, drv_prev;
  logic [7:0] mask_exp;
  logic [2:0] exp_spd[$];
  int err_count, tests_run, nulls_exp, nulls_seen;

  phy_link_port #(.ADDR_W(8)) dut_u (.aclk, .aresetn, .link_interface_mode_select, .link_clock_in, .lreq,
    .phy_link_data_bus_in, .link_drives_bus, .phy_link_data_bus_out, .phy_link_data_bus_oe, .ctl_out, .ctl_oe,
    .link_interrupt_out, .iface_clk_fast, .mode_1394b, .arb_accel_enable, .multispeed_concat_enable,
    .bus_req_valid, .bus_req_speed, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  link_ctrl_model link_u (.aclk, .lreq, .link_drives_bus, .phy_link_data_bus_in, .link_clock_in);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task do_reset(input logic m);
    @(posedge aclk);
    aresetn <= 1'b0;
    link_interface_mode_select <= m;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    mode_exp = m;
    mask_exp = phy_link_pkg::LANE_S100;
    nulls_exp = 0;
    nulls_seen = 0;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  // Sends one bus request and books what the port must do with it
  task bus_req(input logic [2:0] k, input logic [2:0] s);
    if (s[0]) link_u.push_bits({12'h0, 1'b1, k, s, 1'b0}, 8);
    else link_u.push_bits({13'h0, 1'b1, k, s[2:1], 1'b0}, 7);
    if (mode_exp || s == 3'h0 || s == 3'h2 || s == 3'h4) begin
      exp_spd.push_back(s);
      if (!mode_exp) mask_exp = (s == 3'h0) ? 8'h03 : (s == 3'h2) ? 8'h0F : 8'hFF;
    end else nulls_exp++;
  endtask : bus_req

  task settle();
    while (link_u.pending() != 0) @(posedge aclk);
    repeat (6) @(posedge aclk);
  endtask : settle

  // ------------------------------------------------------------
  // Clock, monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (aresetn === 1'b1) begin
      if (bus_req_valid === 1'b1) begin
        if (exp_spd.size() == 0) check(32'h1, 32'h0, "unexpected bus request");
        else check({29'h0, bus_req_speed}, {29'h0, exp_spd.pop_front()}, "bus request speed");
      end
      if (ctl_out === phy_link_pkg::CTL_RECEIVE) begin
        nulls_seen++;
        check({24'h0, phy_link_data_bus_out}, {24'h0, 8'hFF & mask_exp}, "null prefix lanes");
      end
      check({30'h0, phy_link_data_bus_oe, ctl_oe}, {30'h0, {2{!drv_prev}}}, "bus enables");
    end
    drv_prev = link_drives_bus;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, link_interface_mode_select, awvalid, wvalid, bready, arvalid, rready, drv_prev} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    rng = 32'h4591;
    err_count = 0;
    tests_run = 0;
    do_reset(1'b0);
    check({30'h0, mode_1394b, iface_clk_fast}, 32'h0, "legacy mode outputs");
    check({31'h0, link_interrupt_out}, 32'h0, "interrupt unused");
    axi_rd(phy_link_pkg::STATUS_OFFSET);
    check(rd, 32'h0, "status legacy");
    axi_rd(phy_link_pkg::CONTROL_OFFSET);
    check(rd, 32'h0, "control reset");
    axi_wr(phy_link_pkg::CONTROL_OFFSET, 32'h3);
    check({30'h0, arb_accel_enable, multispeed_concat_enable}, 32'h3, "enables set");
    axi_wr(phy_link_pkg::CONTROL_OFFSET, 32'h0);
    check({30'h0, arb_accel_enable, multispeed_concat_enable}, 32'h0, "enables kept clear");
    axi_wr(8'h20, 32'h3);
    check({30'h0, r}, {30'h0, phy_link_pkg::RESP_SLVERR}, "unmapped write");
    axi_wr(phy_link_pkg::STATUS_OFFSET, 32'h7);
    check({30'h0, r}, {30'h0, phy_link_pkg::RESP_SLVERR}, "read-only write");
    axi_rd(8'h24);
    check({rd[29:0], r}, {30'h0, phy_link_pkg::RESP_SLVERR}, "unmapped read");
    for (int s = 0; s < 8; s++) begin
      bus_req(3'(rnd() % 4), 3'(s));
      settle();
    end
    v = rnd();
    bus_req(3'h3, 3'h2);
    link_u.push_bits({3'h0, 1'b1, phy_link_pkg::REQ_WRITE, v[11:0], 1'b0}, 17);
    settle();
    axi_rd(phy_link_pkg::LAST_REQ_OFFSET);
    check(rd & 32'h0700_0FFF, {5'h0, phy_link_pkg::REQ_WRITE, 12'h0, v[11:0]}, "write after bus request");
    bus_req(3'h1, 3'h0);
    link_u.push_bits({11'h0, 1'b1, phy_link_pkg::REQ_READ, v[15:12], 1'b0}, 9);
    settle();
    axi_rd(phy_link_pkg::LAST_REQ_OFFSET);
    check(rd & 32'h0700_0F00, {5'h0, phy_link_pkg::REQ_READ, 12'h0, v[15:12], 8'h0}, "read after bus request");
    link_u.drive_bus(v[23:16], 3);
    settle();
    axi_rd(phy_link_pkg::LINK_DATA_OFFSET);
    check(rd, {24'h0, v[23:16] & mask_exp}, "inbound lanes");
    axi_rd(phy_link_pkg::NULL_COUNT_OFFSET);
    check(rd, 32'(nulls_exp), "null count");
    check(32'(nulls_seen), 32'(nulls_exp), "null packets seen");
    link_interface_mode_select <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(phy_link_pkg::STATUS_OFFSET);
    check({rd[30:0], mode_1394b}, 32'h0, "mode ignored after reset");
    do_reset(1'b1);
    check({30'h0, mode_1394b, iface_clk_fast}, 32'h3, "newer mode outputs");
    for (int s = 0; s < 8; s++) begin
      bus_req(3'(rnd() % 4), 3'(s));
      settle();
    end
    axi_rd(phy_link_pkg::STATUS_OFFSET);
    check(rd, 32'h3, "status newer");
    check(32'(exp_spd.size()), 32'h0, "all requests forwarded");
    conclude();
  end
endmodule : tb_phy_link_port
